// ==== logic/crrb_pkg.sv ====
// Purpose: shared constants and carrier types for the cell result register bank
// Assumes: byte-wide registers, one clock domain
// Notes: offsets are register addresses on the serial register port
package crrb_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CODE_W = 12;
  localparam int CHAN_N = 6;
  localparam int CHAN_W = 3;

  // register addresses
  localparam logic [7:0] CELL4_LOW_OFS = 8'h0D;   // first slot of the pair layout, outside this bank
  localparam logic [7:0] CELL4_HIGH_OFS = 8'h0E;
  localparam logic [7:0] CELL5_LOW_OFS = 8'h0F;
  localparam logic [7:0] CELL5_HIGH_OFS = 8'h10;
  localparam logic [7:0] CELL6_LOW_OFS = 8'h11;
  localparam logic [7:0] CELL6_HIGH_OFS = 8'h12;
  localparam logic [7:0] CELL7_LOW_OFS = 8'h13;
  localparam logic [7:0] CELL7_HIGH_OFS = 8'h14;
  localparam logic [7:0] THERMAL1_LOW_OFS = 8'h15;
  localparam logic [7:0] THERMAL1_HIGH_OFS = 8'h16;
  localparam logic [7:0] THERMAL2_LOW_OFS = 8'h17;
  localparam logic [7:0] THERMAL2_HIGH_OFS = 8'h18;
  localparam logic [7:0] CHAIN_STATUS_OFS = 8'h19;

  // channel indices of the result store
  localparam logic [2:0] CH_CELL4 = 3'h0;
  localparam logic [2:0] CH_CELL5 = 3'h1;
  localparam logic [2:0] CH_CELL6 = 3'h2;
  localparam logic [2:0] CH_CELL7 = 3'h3;
  localparam logic [2:0] CH_THERMAL1 = 3'h4;
  localparam logic [2:0] CH_THERMAL2 = 3'h5;

  // reset values and fills
  localparam logic [11:0] CODE_RESET = 12'h000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [3:0] HIGH_RSVD = 4'h0;
  localparam logic [4:0] STATUS_RSVD = 5'h00;
  localparam logic [2:0] STATUS_RESET = 3'h0;

  // status bit positions
  localparam int STS_CRC_M2S_BIT = 0;
  localparam int STS_CRC_S2M_BIT = 1;
  localparam int STS_ALLOC_FAIL_BIT = 2;

  // one finished conversion from the converter
  typedef struct packed {
    logic [2:0] chan;
    logic [11:0] code;
  } crrb_conv_t;

  // outcome of one three-wire chain port operation, bit order matches the register
  typedef struct packed {
    logic alloc_fail;
    logic crc_s2m;
    logic crc_m2s;
  } crrb_sts_t;
endpackage

// ==== logic/crrb_bank.sv ====
// Purpose: read-only result and chain status registers of a cell monitor
// Assumes: converter and chain port logic run on mclk_i; serial framing sits outside
// Notes: read data is registered, one cycle after the read strobe
//
// Summary of operation
// - low-byte register shows result bits 7..0 of its channel in data bits 7..0; cell4 low at 0x0D is outside and reads zero
// - high-byte register shows result bits 11..8 in bits 3..0, bits 7..4 read zero
// - two thermal inputs have low/high pairs split like the cell channels
// - status register describes only the latest three-wire chain port operation
// - status bit 0 is one on a master-to-slave CRC error, else zero
// - status bit 1 is one on a slave-to-master CRC error, else zero
// - status bit 2 is one when the allocation start write failed; bits 7..3 zero
`timescale 1ns/1ps
`default_nettype none
module crrb_bank (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic conv_valid_i,
  input wire crrb_pkg::crrb_conv_t conv_i,
  input wire logic chain_op_done_i,
  input wire crrb_pkg::crrb_sts_t chain_sts_i,
  input wire logic rd_en_i,
  input wire logic wr_en_i,
  input wire logic [7:0] addr_i,
  output logic [7:0] rdata_o,
  output logic rd_valid_o,
  output logic wr_refused_o
);
  logic [11:0] result [0:5];
  logic [2:0] status;
  logic [7:0] addr_off;
  logic [2:0] rd_chan;
  logic rd_is_high;
  logic rd_in_results;
  logic rd_is_status;
  logic [11:0] sel_code;
  logic [7:0] next_rdata;

  // pair layout: offset from the cell4 low slot gives channel and byte half
  assign addr_off = addr_i - crrb_pkg::CELL4_LOW_OFS;
  assign rd_chan = addr_off[3:1];
  assign rd_is_high = addr_off[0];
  assign rd_in_results = (addr_i >= crrb_pkg::CELL4_HIGH_OFS) && (addr_i <= crrb_pkg::THERMAL2_HIGH_OFS);
  assign rd_is_status = (addr_i == crrb_pkg::CHAIN_STATUS_OFS);
  // an unmapped address selects CODE_RESET instead of the store entry at rd_chan
  assign sel_code = rd_in_results ? result[rd_chan] : crrb_pkg::CODE_RESET;

  // read mux; unmapped addresses answer zero
  assign next_rdata = rd_in_results ? (rd_is_high ? {crrb_pkg::HIGH_RSVD, sel_code[11:8]}
                                                  : sel_code[7:0])
                    : rd_is_status ? {crrb_pkg::STATUS_RSVD, status}
                    : crrb_pkg::BYTE_ZERO;

  // one store entry per channel; a new conversion overwrites its own entry only
  genvar g;
  generate
    for (g = 0; g < crrb_pkg::CHAN_N; g = g + 1) begin : g_store
      always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          result[g] <= crrb_pkg::CODE_RESET;
        end else if (conv_valid_i && (conv_i.chan == 3'(g))) begin
          result[g] <= conv_i.code;
        end
      end
    end
  endgenerate

  // status is replaced whole per operation, so a stale error never lingers
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status <= crrb_pkg::STATUS_RESET;
    end else if (chain_op_done_i) begin
      status <= chain_sts_i;
    end
  end

  // read port; writes are acknowledged as refused and change nothing
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= crrb_pkg::BYTE_ZERO;
      rd_valid_o <= 1'b0;
      wr_refused_o <= 1'b0;
    end else begin
      rdata_o <= rd_en_i ? next_rdata : rdata_o;
      rd_valid_o <= rd_en_i;
      wr_refused_o <= wr_en_i;
    end
  end

  // checks
  sequence s_fail_then_pass;
    chain_op_done_i && chain_sts_i.alloc_fail ##1 chain_op_done_i && !chain_sts_i.alloc_fail;
  endsequence

  sequence s_cell5_update_read;
    conv_valid_i && conv_i.chan == crrb_pkg::CH_CELL5 ##1 rd_en_i && addr_i == crrb_pkg::CELL5_LOW_OFS
      && !conv_valid_i;
  endsequence

  a_read_latency: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rd_en_i |=> rd_valid_o ##1 (rd_valid_o == $past(rd_en_i)))
    else $error("read answer not one cycle after strobe");

  a_cell5_low_map: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    s_cell5_update_read |=> rdata_o == $past(conv_i.code[7:0], 2))
    else $error("cell5 low byte wrong");

  a_cell4_high_map: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rd_en_i && addr_i == crrb_pkg::CELL4_HIGH_OFS |=>
      rdata_o == {crrb_pkg::HIGH_RSVD, $past(result[0][11:8])})
    else $error("cell4 high byte wrong");

  a_high_rsvd_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rd_en_i && rd_in_results && rd_is_high |=> rdata_o[7:4] == crrb_pkg::HIGH_RSVD)
    else $error("high byte reserved bits set");

  a_thermal2_pair: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    conv_valid_i && conv_i.chan == crrb_pkg::CH_THERMAL2 ##1
      rd_en_i && addr_i == crrb_pkg::THERMAL2_HIGH_OFS && !conv_valid_i |=>
      rdata_o[3:0] == $past(conv_i.code[11:8], 2))
    else $error("thermal2 high byte wrong");

  a_latest_alloc: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    s_fail_then_pass |=> !status[crrb_pkg::STS_ALLOC_FAIL_BIT])
    else $error("status kept an older operation");

  a_crc_m2s_bit: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    chain_op_done_i |=> status[crrb_pkg::STS_CRC_M2S_BIT] == $past(chain_sts_i.crc_m2s))
    else $error("m2s crc bit wrong");

  a_crc_s2m_read: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    chain_op_done_i && chain_sts_i.crc_s2m ##1 rd_en_i && rd_is_status && !chain_op_done_i |=>
      rdata_o[crrb_pkg::STS_CRC_S2M_BIT])
    else $error("s2m crc bit not reported");

  a_status_rsvd_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rd_en_i && rd_is_status |=> rdata_o[7:3] == crrb_pkg::STATUS_RSVD)
    else $error("status reserved bits set");

  a_write_no_effect: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_en_i && !chain_op_done_i |=> $stable(status) && wr_refused_o)
    else $error("host write changed status");

  // answers come exactly one cycle after the strobe and never on their own
  a_valid_follows_read: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rd_en_i |=> rd_valid_o)
    else $error("read strobe not answered");

  a_no_stray_valid: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !rd_en_i |=> !rd_valid_o)
    else $error("answer without a read strobe");

  // the host shifts the byte out after the pulse, so it must not move in between
  a_rdata_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !rd_en_i |=> $stable(rdata_o))
    else $error("read data changed without a read");

  // a write leaves nothing behind but its refusal pulse
  a_write_refused: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_en_i |=> wr_refused_o)
    else $error("write not refused");

  a_no_stray_refusal: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !wr_en_i |=> !wr_refused_o)
    else $error("refusal without a write");

  a_write_keeps_store: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_en_i && !conv_valid_i |=> $stable(result[crrb_pkg::CH_CELL5]))
    else $error("host write changed a result");

  // unmapped addresses answer zero instead of a neighbouring slot
  a_unmapped_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rd_en_i && !rd_in_results && !rd_is_status |=> rdata_o == crrb_pkg::BYTE_ZERO)
    else $error("unmapped read not zero");

  // each conversion lands in its own channel entry and nowhere else
  a_cell6_store: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    conv_valid_i && conv_i.chan == crrb_pkg::CH_CELL6 |=>
      result[crrb_pkg::CH_CELL6] == $past(conv_i.code))
    else $error("cell6 result not stored");

  a_thermal1_store: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    conv_valid_i && conv_i.chan == crrb_pkg::CH_THERMAL1 |=>
      result[crrb_pkg::CH_THERMAL1] == $past(conv_i.code))
    else $error("thermal1 result not stored");

  // codes 6 and 7 name no channel; they must not alias onto an entry
  a_spare_chan_ignored: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    conv_valid_i && conv_i.chan > crrb_pkg::CH_THERMAL2 |=>
      $stable(result[crrb_pkg::CH_CELL4]) && $stable(result[crrb_pkg::CH_THERMAL2]))
    else $error("spare channel code changed a result");

  sequence s_cell7_update_read;
    conv_valid_i && conv_i.chan == crrb_pkg::CH_CELL7 ##1 rd_en_i && addr_i == crrb_pkg::CELL7_HIGH_OFS
      && !conv_valid_i;
  endsequence

  a_cell7_high_map: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    s_cell7_update_read |=> rdata_o == {crrb_pkg::HIGH_RSVD, $past(conv_i.code[11:8], 2)})
    else $error("cell7 high byte wrong");

  // status only moves at the end of a chain port operation
  a_status_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !chain_op_done_i |=> $stable(status))
    else $error("status moved between operations");

  a_crc_s2m_bit: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    chain_op_done_i |=> status[crrb_pkg::STS_CRC_S2M_BIT] == $past(chain_sts_i.crc_s2m))
    else $error("s2m crc bit wrong");

  a_alloc_fail_bit: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    chain_op_done_i |=> status[crrb_pkg::STS_ALLOC_FAIL_BIT] == $past(chain_sts_i.alloc_fail))
    else $error("allocation bit wrong");

  // a pass followed at once by a fail must show the fail, not an older result
  sequence s_pass_then_fail;
    chain_op_done_i && !chain_sts_i.alloc_fail ##1 chain_op_done_i && chain_sts_i.alloc_fail;
  endsequence

  a_alloc_fail_latest: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    s_pass_then_fail |=> status[crrb_pkg::STS_ALLOC_FAIL_BIT])
    else $error("status lost the latest failure");

  // the m2s bit must both set and clear as seen from the read port
  sequence s_m2s_err_read;
    chain_op_done_i && chain_sts_i.crc_m2s ##1 rd_en_i && rd_is_status && !chain_op_done_i;
  endsequence

  sequence s_m2s_clean_read;
    chain_op_done_i && !chain_sts_i.crc_m2s ##1 rd_en_i && rd_is_status && !chain_op_done_i;
  endsequence

  a_m2s_err_read: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    s_m2s_err_read |=> rdata_o[crrb_pkg::STS_CRC_M2S_BIT])
    else $error("m2s crc error not reported");

  a_m2s_clean_read: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    s_m2s_clean_read |=> !rdata_o[crrb_pkg::STS_CRC_M2S_BIT])
    else $error("m2s crc bit not cleared");

  // the first edge after each reset release still sees the outputs, the status and the cell5 result cleared
  a_reset_clears: assert property (@(posedge mclk_i)
    $rose(rst_n_i) |-> rdata_o == crrb_pkg::BYTE_ZERO && !rd_valid_o && !wr_refused_o
      && status == crrb_pkg::STATUS_RESET && result[crrb_pkg::CH_CELL5] == crrb_pkg::CODE_RESET)
    else $error("register not cleared by reset");
endmodule
`default_nettype wire

// ==== sim/crrb_host.sv ====
// Purpose: host model driving the register read port
// Assumes: each call starts just after a falling edge
// Notes: strobes are held between calls so back to back ops never toggle twice
`timescale 1ns/1ps
`default_nettype none
module crrb_host (
  input wire logic mclk_i,
  output logic rd_en_o,
  output logic wr_en_o,
  output logic [7:0] addr_o
);
  // idle bus at time zero
  initial begin
    rd_en_o = 1'b0;
    wr_en_o = 1'b0;
    addr_o = 8'h5A;
  end
  // one request per cycle, held until the next call replaces it
  task automatic op(input logic r, input logic w, input logic [7:0] a);
    rd_en_o <= r;
    wr_en_o <= w;
    addr_o <= a;
    @(negedge mclk_i);
  endtask
endmodule
`default_nettype wire

// ==== sim/crrb_bank_tb_top.sv ====
// Purpose: self-checking bench for the result register bank
// Assumes: inputs change on falling edges only
// Notes: each read leaves a note in a queue, matched when rd_valid_o appears
`timescale 1ns/1ps
`default_nettype none
module crrb_bank_tb_top;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic conv_valid_i = 1'b0;
  crrb_pkg::crrb_conv_t conv_i = '0;
  logic chain_op_done_i = 1'b0;
  crrb_pkg::crrb_sts_t chain_sts_i = '0;
  logic rd_en_i, wr_en_i, rd_valid_o, wr_refused_o;
  logic [7:0] addr_i, rdata_o;
  logic [11:0] code [6];
  logic [2:0] sts;
  logic [7:0] q [$];
  int num_errors = 0;
  int compares = 0;
  integer seed = 32'h7a23;
  always #50 mclk_i = ~mclk_i;
  crrb_host host_u (.mclk_i(mclk_i), .rd_en_o(rd_en_i), .wr_en_o(wr_en_i), .addr_o(addr_i));
  crrb_bank dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .conv_valid_i(conv_valid_i), .conv_i(conv_i),
    .chain_op_done_i(chain_op_done_i), .chain_sts_i(chain_sts_i), .rd_en_i(rd_en_i), .wr_en_i(wr_en_i),
    .addr_i(addr_i), .rdata_o(rdata_o), .rd_valid_o(rd_valid_o), .wr_refused_o(wr_refused_o));
  task automatic cmp_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cmp_bit(input string n, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %b got %b", n, e, g);
    end
  endtask
  // expected byte at an address; 0x0D belongs to another bank and reads zero
  function automatic logic [7:0] expv(input logic [7:0] a);
    logic [7:0] k;
    k = a - 8'h0D;
    if (a == 8'h19) return {5'h00, sts};
    if (a < 8'h0E || a > 8'h18) return 8'h00;
    return k[0] ? {4'h0, code[k[3:1]][11:8]} : code[k[3:1]][7:0];
  endfunction
  task automatic chk(input logic [7:0] a);
    q.push_back(expv(a));
    host_u.op(1'b1, 1'b0, a);
  endtask
  // one conversion with the host idle, then in the very next cycle a read of that channel with no conversion
  task automatic conv_read(input logic [2:0] c, input logic [7:0] a);
    conv_valid_i <= 1'b1;
    conv_i <= {c, 12'($random(seed))};
    host_u.op(1'b0, 1'b0, 8'hA5);
    conv_valid_i <= 1'b0;
    code[c] = conv_i.code;
    chk(a);
  endtask
  task automatic stop_test();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // results are sampled mid-cycle, where the registered outputs have settled
  // an answer with no note behind it is a stray pulse, not a free pass
  always @(negedge mclk_i) begin
    if (rd_valid_o === 1'b1) begin
      if (q.size() == 0) cmp_bit("rd_valid_o", 1'b0, 1'b1);
      else cmp_byte("rdata_o", q.pop_front(), rdata_o);
    end
  end
  // main sequence
  initial begin
    foreach (code[i]) code[i] = 12'h000;
    sts = 3'h0;
    repeat (5) @(negedge mclk_i);
    rst_n_i = 1'b1;
    for (int a = 8'h0D; a <= 8'h1A; a++) chk(8'(a));
    // the host holds its strobe, so end the burst before conversions start
    host_u.op(1'b0, 1'b0, 8'h5A);
    // back to back conversions; channel 6 must not land anywhere
    for (int c = 0; c < 7; c++) begin
      conv_valid_i <= 1'b1;
      conv_i <= {3'(c), 12'($random(seed))};
      @(negedge mclk_i);
      if (c < 6) code[c] = conv_i.code;
    end
    conv_valid_i <= 1'b0;
    for (int a = 8'h0E; a <= 8'h18; a++) chk(8'(a));
    // a write is refused and the byte keeps its value
    host_u.op(1'b0, 1'b1, 8'h0F);
    cmp_bit("wr_refused_o", 1'b1, wr_refused_o);
    chk(8'h0F);
    cmp_bit("wr_refused_o", 1'b0, wr_refused_o);
    // isolated conversions read back the cycle after they land
    conv_read(3'h1, 8'h0F);
    conv_read(3'h3, 8'h14);
    conv_read(3'h5, 8'h18);
    // every outcome code replaces the one before
    for (int s = 0; s < 8; s++) begin
      chain_op_done_i <= 1'b1;
      chain_sts_i <= 3'(s);
      host_u.op(1'b0, 1'b0, 8'hA5);
      chain_op_done_i <= 1'b0;
      sts = 3'(s);
      chk(8'h19);
    end
    // fail, pass, fail back to back: only the last operation may show
    chain_op_done_i <= 1'b1;
    chain_sts_i <= 3'h4;
    host_u.op(1'b0, 1'b0, 8'hA5);
    chain_sts_i <= 3'h0;
    host_u.op(1'b0, 1'b0, 8'hA5);
    chain_sts_i <= 3'h4;
    host_u.op(1'b0, 1'b0, 8'hA5);
    chain_op_done_i <= 1'b0;
    sts = 3'h4;
    chk(8'h19);
    // reset again in mid-run, after the last answer has been checked
    host_u.op(1'b0, 1'b0, 8'h5A);
    @(negedge mclk_i);
    rst_n_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    rst_n_i = 1'b1;
    foreach (code[i]) code[i] = 12'h000;
    sts = 3'h0;
    chk(8'h10);
    chk(8'h19);
    chk(8'h18);
    host_u.op(1'b0, 1'b0, 8'h5A);
    repeat (2) @(negedge mclk_i);
    cmp_byte("queue", 8'h00, 8'(q.size()));
    stop_test();
  end
  // the run needs under a hundred cycles; a hang is cut short well after that
  initial begin
    #(2000 * 100);
    num_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
